// ---- rtl/mpbc_pkg.sv ----
package mpbc_pkg;
    // ------------------------------------------------------------
    // Port geometry and bit positions
    // ------------------------------------------------------------
    localparam int unsigned PORT_W       = 8;
    localparam int unsigned BIT_PWM0     = 0;
    localparam int unsigned BIT_PWM1     = 1;
    localparam int unsigned BIT_CPUCK    = 2;
    localparam int unsigned BIT_SLOWCK   = 3;
    localparam int unsigned BIT_SYNC0    = 4;
    localparam int unsigned BIT_SYNC1    = 5;
    localparam int unsigned BIT_UART_TX  = 6;
    localparam int unsigned BIT_UART_RX  = 7;
    localparam int unsigned ANA_LINES    = 4;
    localparam int unsigned ANA_SEL_W    = 2;

    // ------------------------------------------------------------
    // Reset values of the configuration bits
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DIR    = 8'h00;
    localparam logic [7:0] RST_OUT    = 8'h00;
    localparam logic [7:0] RST_OPEN   = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'hFF;
    localparam logic [7:0] RST_ANA    = 8'h00;
    localparam logic [7:0] ALL_ZERO   = 8'h00;
    localparam logic [3:0] LINE_NONE  = 4'h0;
endpackage : mpbc_pkg

// ---- rtl/mpbc_port.sv ----
`timescale 1ns/1ps
// Overview of operation
// [R1] PWM enables replace output value on bits 0,1
// [R2] Clock/PWM overrides leave direction bit in charge
// [R3] Slow clock output drives bit 3
// [R4] CPU clock output drives bit 2
// [R5] CPU clock source follows select bit
// [R6] Sync serial forces bits 5,4 open-drain
// [R7] Sync line values drive bits 4,5
// [R8] Software adds pull-ups for sync lines
// [R9] UART transmit drives bit 6 as output
// [R10] UART receive makes bit 7 an input
// [R11] Priority: analog, peripheral, then digital
// [R12] Analog select bit switches pad to analog
// [R13] Analog: pull-up connects, dir/out pick line
// [R14] Direction one enables output buffer
// [R15] Direction bits reset to zero
// [R16] Input value reads pin levels, no filter
// [R17] Input value reads back driven pins
// [R18] Output values drive when direction set; reset zero
// [R19] Open-drain drives low only; resets push-pull
// [R20] Pull-up only for input or released open-drain
// [R21] Pull-up bits reset to one
// [R22] Bit 1 pulled down during power-on reset
// [R23] Input buffer on except in analog mode
// [R24] Software parks comparator pins in analog
// [R25] Pin inputs synchronised before reading
module mpbc_port (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       por_active,
    // Software configuration
    input  wire logic [7:0] pin_direction_bits,
    input  wire logic [7:0] pin_output_value_bits,
    input  wire logic [7:0] pin_open_drain_bits,
    input  wire logic [7:0] pin_pullup_bits,
    input  wire logic [7:0] pin_analog_select_bits,
    input  wire logic [7:0] cfg_write_strobe,
    // Peripheral enables and signals
    input  wire logic       pwm_first_pin_enable,
    input  wire logic       pwm_second_pin_enable,
    input  wire logic       pwm_first_value,
    input  wire logic       pwm_second_value,
    input  wire logic       slow_clock_out_enable,
    input  wire logic       slow_clock,
    input  wire logic       cpu_clock_out_enable,
    input  wire logic       cpu_clock_select,
    input  wire logic       cpu_clock_div4,
    input  wire logic       cpu_clock_fast,
    input  wire logic       cpu_clock_32k,
    input  wire logic       sync_serial_enable,
    input  wire logic       sync_line0_is_output,
    input  wire logic       sync_line1_is_output,
    input  wire logic       sync_line0_value,
    input  wire logic       sync_line1_value,
    input  wire logic       uart_transmit_enable,
    input  wire logic       uart_receive_enable,
    input  wire logic       uart_tx_value,
    // Pads
    input  wire logic [7:0] pad_in,
    output logic      [7:0] pad_out,
    output logic      [7:0] pad_oe_n,
    output logic      [7:0] pad_pullup_en,
    output logic      [7:0] pad_pulldown_en,
    output logic      [7:0] pad_inbuf_en,
    output logic      [7:0] pad_ana_connect,
    output logic [31:0]     pad_ana_line,
    // Read-back
    output logic      [7:0] pin_input_value_bits,
    output logic      [7:0] cfg_readback_dir,
    output logic      [7:0] cfg_readback_pullup,
    output logic            uart_rx_value,
    output logic            sync_line0_in,
    output logic            sync_line1_in
);
    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] dir_q, out_q, open_q, pull_q, ana_q;
    logic [7:0] sync1_q, sync2_q;

    // Per-bit write of configuration fields
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_q  <= mpbc_pkg::RST_DIR;    // R15
            out_q  <= mpbc_pkg::RST_OUT;    // R18
            open_q <= mpbc_pkg::RST_OPEN;   // R19
            pull_q <= mpbc_pkg::RST_PULLUP; // R21
            ana_q  <= mpbc_pkg::RST_ANA;    // R11
        end else begin
            for (int i = 0; i < mpbc_pkg::PORT_W; i++) begin
                if (cfg_write_strobe[i]) begin
                    dir_q[i]  <= pin_direction_bits[i];
                    out_q[i]  <= pin_output_value_bits[i];
                    open_q[i] <= pin_open_drain_bits[i];
                    pull_q[i] <= pin_pullup_bits[i];
                    ana_q[i]  <= pin_analog_select_bits[i];
                end
            end
        end
    end

    // Two-stage synchroniser for pad levels
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= mpbc_pkg::ALL_ZERO;
            sync2_q <= mpbc_pkg::ALL_ZERO;
        end else begin
            sync1_q <= pad_in;  // R25
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Override resolution
    // ------------------------------------------------------------
    logic [7:0] eff_val, eff_dir, eff_open;
    logic       cpu_ck;

    // CPU clock source choice
    always_comb begin
        cpu_ck = cpu_clock_select ? cpu_clock_32k : cpu_clock_div4; // R5
        if (cpu_clock_select && cpu_clock_fast) begin
            cpu_ck = cpu_clock_fast; // R5
        end
    end

    // Function layer above the digital setup
    always_comb begin
        eff_val  = out_q;
        eff_dir  = dir_q;
        eff_open = open_q;
        if (pwm_first_pin_enable) begin
            eff_val[mpbc_pkg::BIT_PWM0] = pwm_first_value; // R1 R2
        end
        if (pwm_second_pin_enable) begin
            eff_val[mpbc_pkg::BIT_PWM1] = pwm_second_value; // R1 R2
        end
        if (cpu_clock_out_enable) begin
            eff_val[mpbc_pkg::BIT_CPUCK] = cpu_ck; // R4 R2
        end
        if (slow_clock_out_enable) begin
            eff_val[mpbc_pkg::BIT_SLOWCK] = slow_clock; // R3 R2
        end
        if (sync_serial_enable) begin
            eff_open[mpbc_pkg::BIT_SYNC0] = 1'b1; // R6
            eff_open[mpbc_pkg::BIT_SYNC1] = 1'b1;
            eff_dir[mpbc_pkg::BIT_SYNC0]  = sync_line0_is_output;
            eff_dir[mpbc_pkg::BIT_SYNC1]  = sync_line1_is_output;
            eff_val[mpbc_pkg::BIT_SYNC0]  = sync_line0_value; // R7
            eff_val[mpbc_pkg::BIT_SYNC1]  = sync_line1_value; // R7
        end
        if (uart_transmit_enable) begin
            eff_dir[mpbc_pkg::BIT_UART_TX] = 1'b1; // R9
            eff_val[mpbc_pkg::BIT_UART_TX] = uart_tx_value;
        end
        if (uart_receive_enable) begin
            eff_dir[mpbc_pkg::BIT_UART_RX] = 1'b0; // R10
            eff_val[mpbc_pkg::BIT_UART_RX] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pad control, registered
    // ------------------------------------------------------------
    logic [7:0]  drive_d, oe_n_d, pu_d, pd_d, ib_d, ac_d;
    logic [31:0] line_d;

    // Per-bit buffer, pull and analog decode
    always_comb begin
        for (int i = 0; i < mpbc_pkg::PORT_W; i++) begin
            drive_d[i] = eff_val[i];
            // Push-pull drives when dir set; open-drain only pulls low
            oe_n_d[i]  = !(eff_dir[i] && !(eff_open[i] && eff_val[i])); // R14 R18 R19
            pu_d[i]    = pull_q[i] && (!eff_dir[i] || (eff_open[i] && eff_val[i])); // R20
            pd_d[i]    = 1'b0;
            ib_d[i]    = 1'b1; // R23
            ac_d[i]    = 1'b0;
            line_d[i*mpbc_pkg::ANA_LINES +: mpbc_pkg::ANA_LINES] = mpbc_pkg::LINE_NONE;
            if (ana_q[i]) begin
                // Analog wins over every other setup
                oe_n_d[i]  = 1'b1; // R11 R12
                pu_d[i]    = 1'b0;
                ib_d[i]    = 1'b0; // R23
                ac_d[i]    = pull_q[i]; // R13
                if (pull_q[i]) begin
                    line_d[i*mpbc_pkg::ANA_LINES + {dir_q[i], out_q[i]}] = 1'b1; // R13
                end
            end
        end
        if (por_active && !ana_q[mpbc_pkg::BIT_PWM1]) begin
            pd_d[mpbc_pkg::BIT_PWM1] = pull_q[mpbc_pkg::BIT_PWM1]; // R22
            pu_d[mpbc_pkg::BIT_PWM1] = 1'b0;
        end
    end

    // Register all pad-facing outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_out         <= mpbc_pkg::ALL_ZERO;
            pad_oe_n        <= ~mpbc_pkg::ALL_ZERO;
            pad_pullup_en   <= mpbc_pkg::ALL_ZERO;
            pad_pulldown_en <= mpbc_pkg::ALL_ZERO;
            pad_inbuf_en    <= ~mpbc_pkg::ALL_ZERO;
            pad_ana_connect <= mpbc_pkg::ALL_ZERO;
            pad_ana_line    <= '0;
        end else begin
            pad_out         <= drive_d;
            pad_oe_n        <= oe_n_d;
            pad_pullup_en   <= pu_d;
            pad_pulldown_en <= pd_d;
            pad_inbuf_en    <= ib_d;
            pad_ana_connect <= ac_d;
            pad_ana_line    <= line_d;
        end
    end

    // Read-back of pin levels and configuration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_input_value_bits <= mpbc_pkg::ALL_ZERO;
            cfg_readback_dir     <= mpbc_pkg::RST_DIR;
            cfg_readback_pullup  <= mpbc_pkg::RST_PULLUP;
            uart_rx_value        <= 1'b1;
            sync_line0_in        <= 1'b1;
            sync_line1_in        <= 1'b1;
        end else begin
            pin_input_value_bits <= sync2_q; // R16 R17
            cfg_readback_dir     <= dir_q;
            cfg_readback_pullup  <= pull_q;
            uart_rx_value        <= sync2_q[mpbc_pkg::BIT_UART_RX]; // R10
            sync_line0_in        <= sync2_q[mpbc_pkg::BIT_SYNC0];
            sync_line1_in        <= sync2_q[mpbc_pkg::BIT_SYNC1];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_dir_oe;
        @(posedge clk) disable iff (!rst_n)
        (!eff_dir[0] && !ana_q[0]) |=> pad_oe_n[0];
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("output buffer on with direction low"); // R14

    property p_pwm0;
        @(posedge clk) disable iff (!rst_n)
        (pwm_first_pin_enable && !ana_q[0]) |=> (pad_out[0] == $past(pwm_first_value));
    endproperty
    a_pwm0: assert property (p_pwm0) else $error("pwm value not on bit 0"); // R1

    property p_slow_nodir;
        @(posedge clk) disable iff (!rst_n)
        (slow_clock_out_enable && !dir_q[3] && !ana_q[3]) |=> pad_oe_n[3];
    endproperty
    a_slow_nodir: assert property (p_slow_nodir) else $error("slow clock drove without direction"); // R2

    property p_sync_od;
        @(posedge clk) disable iff (!rst_n)
        (sync_serial_enable && sync_line0_value && !ana_q[4]) |=> pad_oe_n[4];
    endproperty
    a_sync_od: assert property (p_sync_od) else $error("sync line 0 drove high"); // R6

    property p_uart_tx;
        @(posedge clk) disable iff (!rst_n)
        (uart_transmit_enable && !ana_q[6]) |=> (!pad_oe_n[6] && pad_out[6] == $past(uart_tx_value));
    endproperty
    a_uart_tx: assert property (p_uart_tx) else $error("uart transmit not driven"); // R9

    property p_ana_inbuf;
        @(posedge clk) disable iff (!rst_n)
        ana_q[7] |=> (!pad_inbuf_en[7] && pad_oe_n[7] && !pad_pullup_en[7]);
    endproperty
    a_ana_inbuf: assert property (p_ana_inbuf) else $error("analog pad kept digital buffers"); // R12

    property p_pull_pp;
        @(posedge clk) disable iff (!rst_n)
        (eff_dir[2] && !eff_open[2]) |=> !pad_pullup_en[2];
    endproperty
    a_pull_pp: assert property (p_pull_pp) else $error("pull-up on push-pull output"); // R20

    property p_in_lat;
        @(posedge clk) disable iff (!rst_n)
        // Only once the pipeline has run three edges out of reset
        $past(rst_n, 3) |-> (pin_input_value_bits == $past(pad_in, 3));
    endproperty
    a_in_lat: assert property (p_in_lat) else $error("input value not three cycles behind pad"); // R25

    property p_por_pd;
        @(posedge clk) disable iff (!rst_n)
        (rst_n && por_active && pull_q[1] && !ana_q[1]) |=> (pad_pulldown_en[1] && !pad_pullup_en[1]);
    endproperty
    a_por_pd: assert property (p_por_pd) else $error("bit 1 not pulled down in power-on"); // R22

    c_pwm: cover property (@(posedge clk) disable iff (!rst_n) pwm_first_pin_enable && dir_q[0]);
    c_sync: cover property (@(posedge clk) disable iff (!rst_n) sync_serial_enable && sync_line1_is_output);
    c_ana: cover property (@(posedge clk) disable iff (!rst_n) ana_q[2] && pull_q[2]);
endmodule : mpbc_port

// ---- test/mpbc_pad_model.sv ----
`timescale 1ns/1ps
module mpbc_pad_model (
    // Clock
    input  wire logic       clk,
    // Block side of the pads
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe_n,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] pulldown_en,
    // Board drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    // Resolved wire levels
    output logic      [7:0] pad_in
);
    logic [7:0] last_q = 8'h00;

    // Chip drive wins, then board drive, then pulls; a bare wire keeps changing
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pullup_en[i]) pad_in[i] = 1'b1;
            else if (pulldown_en[i]) pad_in[i] = 1'b0;
            else pad_in[i] = ~last_q[i];
        end
    end

    // Last level, so a floating wire never settles
    always_ff @(posedge clk) begin
        last_q <= pad_in;
    end
endmodule : mpbc_pad_model

// ---- test/multifunction_port_b_control_tb.sv ----
`timescale 1ns/1ps
module multifunction_port_b_control_tb;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk = 1'b0, rst_n = 1'b0, por = 1'b1;
    logic [7:0]  dir = 8'h00, out = 8'h00, opn = 8'h00, pul = 8'hFF, ana = 8'h00, stb = 8'h00;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00;
    logic [6:0]  en = 7'h00;   // pwm0 pwm1 slow cpu sync tx rx, from bit 0
    logic [11:0] val = 12'h000; // pwm0 pwm1 slow div4 fast k32 sel s0o s1o s0v s1v tx
    logic [7:0]  pad_in, pad_out, oe_n, pu, pd, ibuf, acon, pin_in, rb_dir, rb_pu;
    logic [31:0] aline, eline;
    logic        rx_v, s0_in, s1_in, vb;
    logic [4:0]  tbl [5] = '{5'h09, 5'h06, 5'h15, 5'h1B, 5'h18}; // sel div4 fast k32 expected
    int          num_errors = 0, tests_run = 0;

    // Clock
    always #2.5 clk = ~clk;

    mpbc_port DUT (
        .clk(clk), .rst_n(rst_n), .por_active(por),
        .pin_direction_bits(dir), .pin_output_value_bits(out), .pin_open_drain_bits(opn),
        .pin_pullup_bits(pul), .pin_analog_select_bits(ana), .cfg_write_strobe(stb),
        .pwm_first_pin_enable(en[0]), .pwm_second_pin_enable(en[1]), .pwm_first_value(val[0]),
        .pwm_second_value(val[1]), .slow_clock_out_enable(en[2]), .slow_clock(val[2]),
        .cpu_clock_out_enable(en[3]), .cpu_clock_select(val[6]), .cpu_clock_div4(val[3]),
        .cpu_clock_fast(val[4]), .cpu_clock_32k(val[5]), .sync_serial_enable(en[4]),
        .sync_line0_is_output(val[7]), .sync_line1_is_output(val[8]), .sync_line0_value(val[9]),
        .sync_line1_value(val[10]), .uart_transmit_enable(en[5]), .uart_receive_enable(en[6]),
        .uart_tx_value(val[11]), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(oe_n),
        .pad_pullup_en(pu), .pad_pulldown_en(pd), .pad_inbuf_en(ibuf), .pad_ana_connect(acon),
        .pad_ana_line(aline), .pin_input_value_bits(pin_in), .cfg_readback_dir(rb_dir),
        .cfg_readback_pullup(rb_pu), .uart_rx_value(rx_v), .sync_line0_in(s0_in), .sync_line1_in(s1_in)
    );

    mpbc_pad_model PADS (
        .clk(clk), .pad_out(pad_out), .pad_oe_n(oe_n), .pullup_en(pu), .pulldown_en(pd),
        .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: line map %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Load all five fields of every bit, then wait until pads and input path settle
    task automatic cfg(input logic [7:0] d, input logic [7:0] o, input logic [7:0] p,
                       input logic [7:0] u, input logic [7:0] a);
        @(posedge clk);
        dir <= d;
        out <= o;
        opn <= p;
        pul <= u;
        ana <= a;
        stb <= 8'hFF;
        @(posedge clk);
        stb <= 8'h00;
        step(5);
    endtask : cfg

    task automatic wrap_up();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Watchdog
    initial begin
        #10000;
        num_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        step(6);
        chk8(oe_n, 8'hFF);
        chk8(rb_dir, 8'h00);
        chk8(pad_out, 8'h00);
        chk8(rb_pu, 8'hFF);
        chk8(pu, 8'hFD);
        chk8(pd, 8'h02);
        chk8(ibuf, 8'hFF);
        // Power-on ends and the board drives a pattern
        @(posedge clk);
        por <= 1'b0;
        ext_en <= 8'hFF;
        ext_val <= 8'hA5;
        step(1);
        chk8(pin_in, 8'hFD);
        step(3);
        chk8(pin_in, 8'hA5);
        chk8(pu, 8'hFF);
        chk8(pd, 8'h00);
        // Push-pull output read back
        @(posedge clk);
        ext_en <= 8'h00;
        cfg(8'hFF, 8'h5A, 8'h00, 8'hFF, 8'h00);
        chk8(oe_n, 8'h00);
        chk8(pad_out, 8'h5A);
        chk8(pu, 8'h00);
        chk8(rb_dir, 8'hFF);
        chk8(pin_in, 8'h5A);
        // Open-drain, released bits pulled high
        cfg(8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h00);
        chk8(oe_n, 8'h0F);
        chk8(pad_out & ~oe_n, 8'h00);
        chk8(pu, 8'h0F);
        chk8(pin_in, 8'h0F);
        cfg(8'h00, 8'hFF, 8'h00, 8'h00, 8'h00);
        chk8(oe_n, 8'hFF);
        chk8(pu, 8'h00);
        chk8(rb_pu, 8'h00);
        // Analog over active functions; bits 7:4 parked with no line
        @(posedge clk);
        en <= 7'h7F;
        val <= 12'h880;
        cfg(8'hF0, 8'hCC, 8'h00, 8'h0E, 8'hFF);
        // Pads 1,2,3 on lines 0,1,1; pads 7:4 connected to no line
        eline = 32'h0000_2210;
        chk8(acon, 8'h0E);
        chk32(aline, eline);
        chk8(oe_n, 8'hFF);
        chk8(pu, 8'h00);
        chk8(ibuf, 8'h00);
        // Functions over digital, direction stays with software on bits 3:0; sync and UART set bits 7:4
        @(posedge clk);
        ext_en <= 8'h80;
        ext_val <= 8'h00;
        cfg(8'h80, 8'h00, 8'h00, 8'hFF, 8'h00);
        chk8(oe_n, 8'hAF);
        chk8(pad_out & 8'h50, 8'h40);
        chk8(pu, 8'hAF);
        chk8({7'h00, rx_v}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            vb = k[0];
            @(posedge clk);
            val[3:0] <= {4{vb}};
            cfg(8'h8F, {4'h0, {4{~vb}}}, 8'h00, 8'hFF, 8'h00);
            chk8(pad_out & 8'h0F, {4'h0, {4{vb}}});
            chk8(oe_n & 8'h0F, 8'h00);
        end
        @(posedge clk);
        val[10:8] <= 3'b011;
        step(5);
        chk8(oe_n & 8'h30, 8'h10);
        chk8({7'h00, s0_in}, 8'h01);
        chk8({7'h00, s1_in}, 8'h00);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            val[6] <= tbl[k][4];
            val[3] <= tbl[k][3];
            val[4] <= tbl[k][2];
            val[5] <= tbl[k][1];
            step(2);
            chk8({7'h00, pad_out[2]}, {7'h00, tbl[k][0]});
        end
        @(posedge clk);
        en[6] <= 1'b0;
        ext_en <= 8'h00;
        step(2);
        chk8(oe_n & 8'h80, 8'h00);
        wrap_up();
    end
endmodule : multifunction_port_b_control_tb
